/* pfd_cfg.svh */
// Constants for the fault protection and output disable block.
`ifndef PFD_CFG_SVH
`define PFD_CFG_SVH
`define PFD_NUM_FAULTS 4
`define PFD_NUM_OUTS 6
`define PFD_MAP_RESET 12'h0000
`define PFD_MODE_RESET 4'h0
`define PFD_FILTER_SAMPLES 2
`endif

/* pfd_enable_seq.sv */
// Global enable sequencing: first-set reload pulse and enable rise strobe.
`default_nettype none
`include "pfd_cfg.svh"
module pfd_enable_seq
	import pfd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic modulator_enable,
	output logic reload_now,
	output logic enable_rise
);
	logic en_d_reg;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_d_reg <= 1'b0;
			reload_now <= 1'b0;
			enable_rise <= 1'b0;
		end else begin
			en_d_reg <= modulator_enable;
			reload_now <= modulator_enable & ~en_d_reg;
			enable_rise <= modulator_enable & ~en_d_reg;
		end
	end
endmodule // pfd_enable_seq
`default_nettype wire

/* pfd_fault_disable.sv */
// Fault protection, output disable mapping and enable behaviour for six PWM outputs.
`default_nettype none
`include "pfd_cfg.svh"
module pfd_fault_disable
	import pfd_pkg::*;
#(
	parameter int NF = `PFD_NUM_FAULTS,
	parameter int NO = `PFD_NUM_OUTS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [NF-1:0] fault_in,
	input wire logic soft_disable_bank_x,
	input wire logic soft_disable_bank_y,
	input wire logic [2*NO-1:0] disable_mapping_wdata,
	input wire logic disable_mapping_we,
	input wire logic [NF-1:0] fault_reenable_mode,
	input wire logic [NF-1:0] fault_interrupt_enable,
	input wire logic [NF-1:0] fault_acknowledge,
	input wire logic cycle_start,
	input wire logic [NO-1:0] pwm_level,
	input wire logic [NO-1:0] inactive_level,
	input wire logic manual_output_control,
	input wire logic [NO-1:0] manual_output_level,
	input wire logic modulator_enable,
	input wire logic reload_interrupt_enable,
	input wire logic reload_flag_clear,
	input wire logic load_confirm,
	input wire logic current_sense_on,
	input wire logic complementary_mode,
	output logic [NO-1:0] pwm_out,
	output logic [NO-1:0] pwm_oe,
	output logic [NO-1:0] out_disabled,
	output logic [2*NO-1:0] disable_mapping,
	output logic [NF-1:0] fault_pin_state,
	output logic [NF-1:0] fault_event_flag,
	output logic [NF-1:0] fault_irq,
	output logic reload_flag,
	output logic reload_irq,
	output logic reload_pulse,
	output logic first_cycle_odd_values,
	output logic use_reset_values
);
	////////////////////////////////////////////////////////////////////////////
	pfd_fault_if flt();
	logic reload_now;
	logic enable_rise;
	logic map_locked_reg;
	logic [NF-1:0] fault_active_reg;
	logic [1:0] soft_active_reg;
	logic [1:0] bank_dis;
	logic reenable_point;
	logic loaded_reg;

	pfd_fault_filter #(.N(NF)) u_filter (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.fault_in(fault_in),
		.flt(flt)
	);

	pfd_enable_seq u_enable (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.modulator_enable(modulator_enable),
		.reload_now(reload_now),
		.enable_rise(enable_rise)
	);

	// Map decoding is shared by both banks.
	function automatic pfd_outs_t map_bank(input logic dis, input pfd_outs_t bits);
		map_bank = dis ? bits : '0;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Disable mapping: the first write sticks so a runaway program cannot unmask outputs.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			disable_mapping <= `PFD_MAP_RESET;
			map_locked_reg <= 1'b0;
		end else if (disable_mapping_we && !map_locked_reg) begin
			disable_mapping <= disable_mapping_wdata;
			map_locked_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin state and event flags.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_pin_state <= '0;
		end else begin
			fault_pin_state <= flt.pin_state;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_event_flag <= '0;
		end else begin
			for (int i = 0; i < NF; i++) begin
				// A new rise beats an acknowledge in the same cycle.
				if (flt.rise[i]) fault_event_flag[i] <= 1'b1;
				else if (fault_acknowledge[i]) fault_event_flag[i] <= 1'b0;
			end
		end
	end

	// Request latches; there is no vector fetch input, so a fetch cannot disturb them.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_irq <= '0;
		end else begin
			for (int i = 0; i < NF; i++) begin
				if (!fault_interrupt_enable[i]) fault_irq[i] <= 1'b0;
				else if (flt.rise[i]) fault_irq[i] <= 1'b1;
				else if (fault_acknowledge[i]) fault_irq[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Manual output control has no cycles, so every clock is a re-enable point.
	assign reenable_point = cycle_start | manual_output_control;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_active_reg <= '0;
		end else begin
			for (int i = 0; i < NF; i++) begin
				if (flt.rise[i] || flt.pin_state[i]) begin
					if (flt.rise[i] || fault_reenable_mode[i]) fault_active_reg[i] <= 1'b1;
				end
				if (fault_active_reg[i] && reenable_point && !flt.rise[i]) begin
					if (fault_reenable_mode[i]) begin
						if (!flt.pin_state[i]) fault_active_reg[i] <= 1'b0;
					end else if (!fault_event_flag[i]) begin
						if (i % 2 == 0) fault_active_reg[i] <= 1'b0;
						else if (!fault_in[i]) fault_active_reg[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			soft_active_reg <= 2'b00;
		end else begin
			if (soft_disable_bank_x) soft_active_reg[0] <= 1'b1;
			else if (reenable_point) soft_active_reg[0] <= 1'b0;
			if (soft_disable_bank_y) soft_active_reg[1] <= 1'b1;
			else if (reenable_point) soft_active_reg[1] <= 1'b0;
		end
	end

	// Raw rises are included so a fault disables in its detection cycle.
	assign bank_dis[0] = |fault_active_reg[1:0] | |flt.rise[1:0] | soft_disable_bank_x | soft_active_reg[0];
	assign bank_dis[1] = |fault_active_reg[3:2] | |flt.rise[3:2] | soft_disable_bank_y | soft_active_reg[1];

	////////////////////////////////////////////////////////////////////////////
	// Output stage; the generator levels keep running underneath any disable.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_disabled <= '0;
			pwm_out <= '0;
			pwm_oe <= '0;
		end else begin
			pfd_outs_t dis;
			pfd_outs_t src;
			dis = map_bank(bank_dis[0], disable_mapping[NO-1:0])
				| map_bank(bank_dis[1], disable_mapping[2*NO-1:NO]);
			src = manual_output_control ? manual_output_level : pwm_level;
			out_disabled <= dis;
			for (int j = 0; j < NO; j++) begin
				// Dead time is inserted after this stage, so a setting change here cannot shorten it.
				pwm_out[j] <= dis[j] ? inactive_level[j] : src[j];
			end
			pwm_oe <= {NO{modulator_enable | manual_output_control}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reload flag; a fresh reload wins over a clear in the same cycle.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reload_flag <= 1'b0;
			reload_irq <= 1'b0;
			reload_pulse <= 1'b0;
		end else begin
			reload_pulse <= reload_now;
			if (reload_now) reload_flag <= 1'b1;
			else if (reload_flag_clear) reload_flag <= 1'b0;
			reload_irq <= reload_interrupt_enable & (reload_flag | reload_now);
		end
	end

	// Tracks whether a load confirm ever happened since reset.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			loaded_reg <= 1'b0;
			use_reset_values <= 1'b0;
		end else begin
			if (load_confirm) loaded_reg <= 1'b1;
			if (enable_rise) use_reset_values <= ~(loaded_reg | load_confirm);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			first_cycle_odd_values <= 1'b0;
		end else begin
			if (enable_rise && complementary_mode && current_sense_on) first_cycle_odd_values <= 1'b1;
			else if (cycle_start) first_cycle_odd_values <= 1'b0;
		end
	end
endmodule // pfd_fault_disable
`default_nettype wire

/* pfd_fault_disable_assertions.sv */
// Concurrent checks on the ports of the fault protection block.
`default_nettype none
module pfd_fault_disable_assertions
	import pfd_pkg::*;
#(parameter int NF = 4, parameter int NO = 6) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [NF-1:0] fault_in,
	input wire logic soft_disable_bank_x,
	input wire logic [NF-1:0] fault_acknowledge,
	input wire logic modulator_enable,
	input wire logic [NO-1:0] pwm_oe,
	input wire logic [NO-1:0] out_disabled,
	input wire logic [2*NO-1:0] disable_mapping,
	input wire logic [NF-1:0] fault_pin_state,
	input wire logic [NF-1:0] fault_event_flag,
	input wire logic [NF-1:0] fault_irq,
	input wire logic reload_flag,
	input wire logic reload_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NF-1:0] in_d1, in_d2, in_d3, pin_d;
	wire logic [NF-1:0] pin_rise = fault_pin_state & ~pin_d;
	// Three cycles of pin history let the filter check accept either pipeline alignment.
	always_ff @(posedge sys_clk) begin
		in_d1 <= fault_in;
		in_d2 <= in_d1;
		in_d3 <= in_d2;
		pin_d <= fault_pin_state;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_filter_two: assert property ((pin_rise & ~((in_d1 & in_d2) | (in_d2 & in_d3))) == 0)
		else $error("Pin state rose without two high samples.");
	chk_irq_flag: assert property ((fault_irq & ~fault_event_flag) == 0)
		else $error("Fault request without its event flag.");
	chk_ack_clears: assert property (fault_acknowledge[0] && (fault_in[0] | in_d1[0] | in_d2[0]) == 0
		|=> !fault_event_flag[0]) else $error("Acknowledge left the event flag set.");
	chk_soft_disable: assert property (soft_disable_bank_x |-> ##[1:3]
		(out_disabled & disable_mapping[5:0]) == disable_mapping[5:0]) else $error("Soft disable missed outputs.");
	chk_fault_force: assert property ((pin_rise[0] | pin_rise[1]) |->
		(out_disabled & disable_mapping[5:0]) == disable_mapping[5:0]) else $error("Fault left outputs on.");
	chk_map_once: assert property (disable_mapping != 0 |=> $stable(disable_mapping))
		else $error("Mapping changed after the first write.");
	chk_reload_rise: assert property ($rose(modulator_enable) |-> ##[1:3] (reload_pulse && reload_flag))
		else $error("Enable did not reload.");
	chk_drive_on: assert property (modulator_enable [*4] |-> pwm_oe == '1)
		else $error("Pins not driven while enabled.");
	cov_fault_rise: cover property (pin_rise != 0);
	cov_request: cover property (fault_irq != 0);
	cov_reload: cover property (reload_pulse);
endmodule // pfd_fault_disable_assertions
bind pfd_fault_disable pfd_fault_disable_assertions #(.NF(NF), .NO(NO)) i_pfd_fault_disable_assertions (.*);
`default_nettype wire

/* pfd_fault_disable_tb_top.sv */
// Self-checking bench for the fault protection and output disable block.
`default_nettype none
module pfd_fault_disable_tb_top
	import pfd_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, resetn = 1'b0, soft_disable_bank_x = 1'b0, soft_disable_bank_y = 1'b0;
	logic disable_mapping_we = 1'b0, cycle_start = 1'b0, manual_output_control = 1'b0, modulator_enable = 1'b0;
	logic reload_interrupt_enable = 1'b0, reload_flag_clear = 1'b0, load_confirm = 1'b0;
	logic current_sense_on = 1'b0, complementary_mode = 1'b0;
	logic [11:0] disable_mapping_wdata = '0, disable_mapping, map;
	logic [3:0] fault_reenable_mode = '0, fault_interrupt_enable = '0, fault_acknowledge = '0;
	logic [3:0] fault_in, fault_pin_state, fault_event_flag, fault_irq;
	pfd_outs_t pwm_level = '0, inactive_level = '0, manual_output_level = '0, pwm_out, pwm_oe, out_disabled, exp_dis;
	logic reload_flag, reload_irq, reload_pulse, first_cycle_odd_values, use_reset_values;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	pfd_fault_drive_model i_pfd_fault_drive_model (.*);
	pfd_fault_disable i_pfd_fault_disable (.*);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cs();
		cycle_start = 1'b1;
		w(1);
		cycle_start = 1'b0;
	endtask
	task automatic ack(input logic [3:0] a);
		fault_acknowledge = a;
		w(1);
		fault_acknowledge = '0;
	endtask
	// Bank X owns output 0 and bank Y output 1, so each bank's effect can be told apart.
	function automatic pfd_outs_t dis(input logic bx, input logic by);
		return (bx ? map[5:0] : 6'h00) | (by ? map[11:6] : 6'h00);
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		map = 12'($urandom(32'hf203_097f));
		map = (12'($urandom) & 12'hf3c) | 12'h081;
		pwm_level = 6'($urandom);
		manual_output_level = 6'($urandom);
		w(3);
		resetn = 1'b1;
		w(1);
		chk("oe off", pwm_oe, 0);
		disable_mapping_wdata = map;
		disable_mapping_we = 1'b1;
		w(1);
		disable_mapping_wdata = ~map;
		w(1);
		disable_mapping_we = 1'b0;
		w(1);
		chk("mapping", disable_mapping, map);
		fault_interrupt_enable = 4'h1;
		i_pfd_fault_drive_model.hold(4'h1, 1);
		w(3);
		chk("glitch", fault_event_flag, 0);
		i_pfd_fault_drive_model.hold(4'h1, 2);
		w(2);
		chk("flag", fault_event_flag, 4'h1);
		chk("request", fault_irq, 4'h1);
		chk("x fault", out_disabled & 6'h03, dis(1, 0) & 6'h03);
		cs();
		w(2);
		chk("unacked", out_disabled[0], 1'b1);
		ack(4'h1);
		chk("ack", {fault_irq, fault_event_flag}, 0);
		cs();
		w(2);
		chk("reenable", out_disabled & 6'h03, 0);
		$display("test filter done");
		fault_interrupt_enable = 4'h2;
		fork
			i_pfd_fault_drive_model.hold(4'h6, 14);
		join_none
		w(5);
		chk("pin high", fault_pin_state, 4'h6);
		chk("request 2", fault_irq, 4'h2);
		fault_interrupt_enable = '0;
		w(2);
		chk("flag kept", {fault_irq, fault_event_flag}, 8'h06);
		ack(4'h6);
		cs();
		w(2);
		chk("pair", out_disabled & 6'h03, dis(1, 0) & 6'h03);
		w(6);
		cs();
		w(2);
		chk("pair low", out_disabled & 6'h03, 0);
		chk("pin low", fault_pin_state, 0);
		$display("test manual done");
		fault_reenable_mode = 4'h1;
		fork
			i_pfd_fault_drive_model.hold(4'h1, 8);
		join_none
		w(4);
		ack(4'h1);
		cs();
		w(2);
		chk("auto high", out_disabled[0], 1'b1);
		w(4);
		chk("auto wait", out_disabled[0], 1'b1);
		cs();
		w(2);
		chk("auto", out_disabled & 6'h03, 0);
		fault_reenable_mode = '0;
		manual_output_control = 1'b1;
		i_pfd_fault_drive_model.hold(4'h1, 2);
		w(2);
		ack(4'h1);
		w(2);
		chk("manual ctl", out_disabled & 6'h03, 0);
		chk("manual oe", pwm_oe, 6'h3f);
		chk("manual lvl", pwm_out, manual_output_level);
		manual_output_control = 1'b0;
		$display("test auto done");
		fault_interrupt_enable = 4'hf;
		repeat (12) begin
			soft_disable_bank_x = 1'($urandom);
			soft_disable_bank_y = 1'($urandom);
			inactive_level = 6'($urandom);
			exp_dis = dis(soft_disable_bank_x, soft_disable_bank_y);
			w(3);
			chk("soft", out_disabled, exp_dis);
			chk("inactive", pwm_out & exp_dis, inactive_level & exp_dis);
			chk("running", pwm_out & ~exp_dis, pwm_level & ~exp_dis);
			chk("soft flag", {fault_irq, fault_event_flag}, 0);
			soft_disable_bank_x = 1'b0;
			soft_disable_bank_y = 1'b0;
			w(2);
			chk("soft held", out_disabled, exp_dis);
			cs();
			w(2);
		end
		chk("soft off", out_disabled, 0);
		$display("test soft done");
		reload_interrupt_enable = 1'b1;
		complementary_mode = 1'b1;
		current_sense_on = 1'b1;
		modulator_enable = 1'b1;
		w(4);
		chk("reload", {reload_flag, reload_irq, pwm_oe}, 8'hff);
		chk("odd first", first_cycle_odd_values, 1'b1);
		chk("unloaded", use_reset_values, 1'b1);
		cs();
		w(1);
		chk("odd done", first_cycle_odd_values, 1'b0);
		modulator_enable = 1'b0;
		w(4);
		chk("oe drop", pwm_oe, 0);
		// Software confirms its loads before enabling again.
		load_confirm = 1'b1;
		reload_flag_clear = 1'b1;
		w(1);
		reload_flag_clear = 1'b0;
		w(1);
		chk("flag clear", {reload_flag, reload_irq}, 2'b00);
		modulator_enable = 1'b1;
		w(4);
		chk("loaded", {reload_flag, use_reset_values}, 2'b10);
		$display("test enable done");
		summarize();
	end
endmodule // pfd_fault_disable_tb_top
`default_nettype wire

/* pfd_fault_drive_model.sv */
// Drive-circuit model that raises fault levels on the fault pins.
`default_nettype none
module pfd_fault_drive_model (
	input wire logic sys_clk,
	output logic [3:0] fault_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial fault_in = 4'h0;
	// Pins return low after each event, so the filter always sees a fresh rise.
	task automatic hold(input logic [3:0] pins, input int n);
		@(negedge sys_clk) fault_in = pins;
		repeat (n) @(negedge sys_clk);
		fault_in = 4'h0;
	endtask
endmodule // pfd_fault_drive_model
`default_nettype wire

/* pfd_fault_filter.sv */
// Two-sample fault input filter for all fault pins.
`default_nettype none
`include "pfd_cfg.svh"
module pfd_fault_filter
	import pfd_pkg::*;
#(
	parameter int N = `PFD_NUM_FAULTS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [N-1:0] fault_in,
	pfd_fault_if.filt flt
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_filt
			pfd_filt_state_t state_reg;
			logic pin_reg;
			logic rise_reg;
			// A high must follow a low cycle and hold for two samples before it counts.
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					state_reg <= PFD_FILT_IDLE;
					pin_reg <= 1'b0;
					rise_reg <= 1'b0;
				end else begin
					rise_reg <= 1'b0;
					case (state_reg)
						PFD_FILT_IDLE: begin
							if (!fault_in[g]) state_reg <= PFD_FILT_ARM;
						end
						PFD_FILT_ARM: begin
							if (fault_in[g]) state_reg <= PFD_FILT_HIGH;
						end
						PFD_FILT_HIGH: begin
							if (fault_in[g]) begin
								pin_reg <= 1'b1;
								rise_reg <= 1'b1;
								state_reg <= PFD_FILT_IDLE;
							end else begin
								state_reg <= PFD_FILT_ARM;
							end
						end
						default: state_reg <= PFD_FILT_IDLE;
					endcase
					if (pin_reg && !fault_in[g]) pin_reg <= 1'b0;
				end
			end
			assign flt.pin_state[g] = pin_reg;
			assign flt.rise[g] = rise_reg;
		end
	endgenerate
endmodule // pfd_fault_filter
`default_nettype wire

/* pfd_fault_if.sv */
// Interface carrying filtered fault state between filter and disable logic.
`default_nettype none
interface pfd_fault_if;
	logic [3:0] pin_state;
	logic [3:0] rise;
	modport filt (output pin_state, output rise);
	modport core (input pin_state, input rise);
endinterface
`default_nettype wire

/* pfd_pkg.sv */
// Types shared by the fault protection and output disable block.
`default_nettype none
package pfd_pkg;
	typedef enum logic [2:0] {
		PFD_FILT_IDLE = 3'b001,
		PFD_FILT_ARM = 3'b010,
		PFD_FILT_HIGH = 3'b100
	} pfd_filt_state_t;
	typedef logic [5:0] pfd_outs_t;
endpackage
`default_nettype wire
